/* File: logic/dbg_opt_loader.sv */
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "dbg_opt_consts.svh"
// Operation
// RULE_01: Enable 0 and erase-control 0 keeps debugging disabled.
// RULE_02: Enable 1 and erase-control 0 enables debugging and erases flash on a failed ID check.
// RULE_03: Enable 1 and erase-control 1 enables debugging and keeps flash on a failed ID check.
// RULE_04: The programmer places enable at bit 7 and erase-control at bit 0.
// RULE_05: The programmer writes 000010B into bits 6 to 1; enable 0 with erase-control 1 is barred.
// RULE_06: Bits 3 to 1 may be overwritten while debugging, so they are not trusted afterwards; the code masks them on readback only while ocdActive is high.
// RULE_07: Under boot swap the byte is fetched from 010C3H instead of 000C3H.
// RULE_08: Under boot swap the whole four-byte option area moves to the 010C0H range.
// RULE_09: A byte of 85H decodes as debugging enabled without erase on failure.
// RULE_10: The byte is latched once after reset release and held until the next reset.
// RULE_11: A barred combination or wrong fixed pattern raises a configuration error.
module dbg_opt_loader (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        bootSwap,
	input  wire logic        ocdActive,
	output logic             nvmReq,
	output logic      [16:0] nvmAddr,
	input  wire logic        nvmAck,
	input  wire logic  [7:0] nvmData,
	input  wire logic  [1:0] optIdx,
	output logic      [16:0] optAddr,
	output logic             cpuHold,
	output logic             dbgEnable,
	output logic             eraseOnFail,
	output logic             cfgError,
	input  wire logic  [3:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	// ----------------------------------------
	// Pin sync
	// ----------------------------------------
	logic                        swapMeta_r;
	logic                        swapSync_r;
	logic                        ocdMeta_r;
	logic                        ocdSync_r;

	always_ff @(posedge clk) begin
		swapMeta_r <= bootSwap;
		swapSync_r <= swapMeta_r;
		ocdMeta_r  <= ocdActive;
		ocdSync_r  <= ocdMeta_r;
	end

	// ----------------------------------------
	// Loader state
	// ----------------------------------------
	dbg_opt_pkg::load_state_e    state_r;
	dbg_opt_pkg::load_state_e    state_nxt;
	logic                  [7:0] byte_r;
	logic                  [7:0] byte_nxt;
	logic                        swap_r;
	logic                        swap_nxt;
	logic                        swCtrl_r;
	logic                        swCtrl_nxt;
	logic                        rdValid_r;
	logic                        rdValid_nxt;
	logic                 [31:0] rdData_r;
	logic                 [31:0] rdData_nxt;
	dbg_opt_pkg::dbg_ctrl_s      dec;
	dbg_opt_pkg::dbg_ctrl_s      ctrl_r;
	dbg_opt_pkg::dbg_ctrl_s      ctrl_nxt;
	nvm_rd_if                    nvm ();

	function automatic logic [16:0] areaAddr(input logic swap, input logic [1:0] idx);
		areaAddr = (swap ? `OPT_AREA_ALT : `OPT_AREA_BASE) | {15'h0000, idx};  // RULE_08
	endfunction : areaAddr

	// Decode the incoming byte so the controls land with it, never a cycle late
	opt_byte_decode u_dec (
		.optByte (byte_nxt),
		.ctrl    (dec)
	);

	assign nvm.ack  = nvmAck;
	assign nvm.data = nvmData;
	assign nvmReq   = nvm.req;
	assign nvmAddr  = nvm.addr;

	always_comb begin
		state_nxt = state_r;
		byte_nxt  = byte_r;
		swap_nxt  = swap_r;
		ctrl_nxt  = ctrl_r;
		case (state_r)
			dbg_opt_pkg::LD_IDLE: begin
				swap_nxt  = swapSync_r | swCtrl_r;
				state_nxt = dbg_opt_pkg::LD_REQ;
			end
			dbg_opt_pkg::LD_REQ: begin
				state_nxt = dbg_opt_pkg::LD_WAIT;
			end
			dbg_opt_pkg::LD_WAIT: begin
				if (nvm.ack) begin
					byte_nxt  = nvm.data;                 // RULE_10
					ctrl_nxt  = dec;                      // RULE_10
					state_nxt = dbg_opt_pkg::LD_DONE;
				end
			end
			dbg_opt_pkg::LD_DONE: begin
				// Hold forever; only reset restarts the fetch
				state_nxt = dbg_opt_pkg::LD_DONE;        // RULE_10
			end
			default: begin
				state_nxt = dbg_opt_pkg::LD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= dbg_opt_pkg::LD_IDLE;
			byte_r  <= `DBG_BYTE_RESET;
			swap_r  <= 1'b0;
			ctrl_r  <= '0;
		end else begin
			state_r <= state_nxt;
			byte_r  <= byte_nxt;
			swap_r  <= swap_nxt;
			ctrl_r  <= ctrl_nxt;
		end
	end

	logic loaded;
	assign loaded   = (state_r == dbg_opt_pkg::LD_DONE);
	assign nvm.req  = (state_r == dbg_opt_pkg::LD_WAIT);
	assign nvm.addr = swap_r ? `OPT_DBG_ADDR_ALT : `OPT_DBG_ADDR;  // RULE_07
	assign optAddr  = areaAddr(swap_r, optIdx);                    // RULE_08
	assign cpuHold  = ~loaded;                                     // RULE_10

	// Decoded outputs only valid once loaded; disabled before
	assign dbgEnable   = loaded & ctrl_r.dbgEnable;   // RULE_01
	assign eraseOnFail = loaded & ctrl_r.eraseOnFail; // RULE_02
	assign cfgError    = loaded & ctrl_r.cfgError;    // RULE_11

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// Reads answer one cycle later; writes never stall
	always_comb begin
		swCtrl_nxt  = swCtrl_r;
		rdValid_nxt = 1'b0;
		rdData_nxt  = rdData_r;
		if (avs_write && avs_address == `REG_CTRL)
			swCtrl_nxt = avs_writedata[`CTRL_SWAP];
		if (avs_read && !rdValid_r) begin
			rdValid_nxt = 1'b1;
			rdData_nxt  = 32'h0000_0000;
			case (avs_address)
				`REG_DBG_BYTE: begin
					// Bits 3 to 1 may be rewritten by the debugger; mask them while ocdActive is high
					rdData_nxt[7:0] = ocdSync_r
						? (byte_r & ~{1'b0, `DBG_VOL_MASK, 1'b0})  // RULE_06
						: byte_r;
				end
				`REG_STATUS: begin
					rdData_nxt[`ST_LOADED]  = loaded;
					rdData_nxt[`ST_DBG_EN]  = dbgEnable;
					rdData_nxt[`ST_ERASE]   = eraseOnFail;
					rdData_nxt[`ST_CFG_ERR] = cfgError;
					rdData_nxt[`ST_SWAP]    = swap_r;
				end
				`REG_CTRL: begin
					rdData_nxt[`CTRL_SWAP] = swCtrl_r;
				end
				`REG_ALT_BYTE: begin
					rdData_nxt[16:0] = nvm.addr;
				end
				default: begin
					rdData_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			swCtrl_r  <= 1'b0;
			rdValid_r <= 1'b0;
			rdData_r  <= 32'h0000_0000;
		end else begin
			swCtrl_r  <= swCtrl_nxt;
			rdValid_r <= rdValid_nxt;
			rdData_r  <= rdData_nxt;
		end
	end

	assign avs_readdata    = rdData_r;
	assign avs_waitrequest = avs_read & ~rdValid_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_prohibited_flags: assert property (@(posedge clk) disable iff (rst)
		(loaded && !byte_r[`DBG_EN_BIT] && byte_r[`DBG_ERSD_BIT]) |-> cfgError) // RULE_11
		else $error("barred combination not flagged");
	a_fixed_pattern: assert property (@(posedge clk) disable iff (rst)
		(loaded && byte_r[`DBG_FIX_HI:`DBG_FIX_LO] != `DBG_FIX_VAL) |-> cfgError) // RULE_11
		else $error("bad fixed pattern not flagged");
	a_disable_decode: assert property (@(posedge clk) disable iff (rst)
		(loaded && byte_r[`DBG_EN_BIT] == 1'b0) |-> !dbgEnable && !eraseOnFail) // RULE_01
		else $error("debug not disabled");
	a_erase_decode: assert property (@(posedge clk) disable iff (rst)
		(loaded && byte_r[`DBG_EN_BIT] && !byte_r[`DBG_ERSD_BIT])
		|-> dbgEnable && eraseOnFail) // RULE_02
		else $error("erase mode wrong");
	a_keep_decode: assert property (@(posedge clk) disable iff (rst)
		(loaded && byte_r[`DBG_EN_BIT] && byte_r[`DBG_ERSD_BIT])
		|-> dbgEnable && !eraseOnFail) // RULE_03
		else $error("keep mode wrong");
	a_byte_85h: assert property (@(posedge clk) disable iff (rst)
		(loaded && byte_r == 8'h85) |-> dbgEnable && !eraseOnFail && !cfgError) // RULE_09
		else $error("85H decoded wrong");
	a_swap_address: assert property (@(posedge clk) disable iff (rst)
		nvm.req |-> nvm.addr == (swap_r ? `OPT_DBG_ADDR_ALT : `OPT_DBG_ADDR)) // RULE_07
		else $error("fetch address wrong");
	a_area_redirect: assert property (@(posedge clk) disable iff (rst)
		swap_r |-> optAddr[16:2] == `OPT_AREA_ALT >> 2) // RULE_08
		else $error("area not redirected");
	a_latch_hold: assert property (@(posedge clk) disable iff (rst)
		loaded |=> loaded && $stable(byte_r) && $stable(dbgEnable)) // RULE_10
		else $error("latched byte changed");
	a_hold_release: assert property (@(posedge clk) disable iff (rst)
		(state_r == dbg_opt_pkg::LD_WAIT && nvm.ack) |-> ##2 !cpuHold) // RULE_10
		else $error("cpu hold not released");
	a_volatile_mask: assert property (@(posedge clk) disable iff (rst)
		(avs_read && !rdValid_r && ocdSync_r && avs_address == `REG_DBG_BYTE)
		|=> avs_readdata[3:1] == 3'h0) // RULE_06
		else $error("volatile bits not masked");
endmodule : dbg_opt_loader

/* File: logic/opt_byte_decode.sv */
`timescale 1ns/100ps
`include "dbg_opt_consts.svh"
module opt_byte_decode (
	input  wire logic              [7:0] optByte,
	output dbg_opt_pkg::dbg_ctrl_s       ctrl
);
	logic       enBit;
	logic       ersdBit;
	logic [5:0] fixBits;

	always_comb begin
		enBit   = optByte[`DBG_EN_BIT];
		ersdBit = optByte[`DBG_ERSD_BIT];
		fixBits = optByte[`DBG_FIX_HI:`DBG_FIX_LO];
		ctrl.dbgEnable   = enBit;                       // RULE_01 RULE_02 RULE_03 RULE_09
		ctrl.eraseOnFail = enBit & ~ersdBit;            // RULE_02 RULE_03
		ctrl.cfgError    = (~enBit & ersdBit)           // RULE_11
			| (fixBits != `DBG_FIX_VAL);
	end
endmodule : opt_byte_decode

/* File: pkg/dbg_opt_consts.svh */
`ifndef DBG_OPT_CONSTS_SVH
`define DBG_OPT_CONSTS_SVH

// ----------------------------------------
// Option area addresses
// ----------------------------------------
`define OPT_AREA_BASE    17'h000C0
`define OPT_AREA_ALT     17'h010C0
`define OPT_DBG_ADDR     17'h000C3
`define OPT_DBG_ADDR_ALT 17'h010C3
`define OPT_DBG_IDX      2'h3

// ----------------------------------------
// Debug option byte fields
// ----------------------------------------
`define DBG_EN_BIT       7
`define DBG_ERSD_BIT     0
`define DBG_FIX_HI       6
`define DBG_FIX_LO       1
`define DBG_FIX_VAL      6'h02
`define DBG_VOL_MASK     6'h07
`define DBG_BYTE_RESET   8'h00

// ----------------------------------------
// Register map (word addresses)
// ----------------------------------------
`define REG_DBG_BYTE     4'h0
`define REG_STATUS       4'h1
`define REG_CTRL         4'h2
`define REG_ALT_BYTE     4'h3

`define ST_LOADED        0
`define ST_DBG_EN        1
`define ST_ERASE         2
`define ST_CFG_ERR       3
`define ST_SWAP          4
`define CTRL_SWAP        0

`endif

/* File: pkg/dbg_opt_pkg.sv */
package dbg_opt_pkg;
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_REQ  = 2'b01,
		LD_WAIT = 2'b11,
		LD_DONE = 2'b10
	} load_state_e;

	typedef struct packed {
		logic dbgEnable;
		logic eraseOnFail;
		logic cfgError;
	} dbg_ctrl_s;
endpackage : dbg_opt_pkg

/* File: pkg/nvm_rd_if.sv */
`timescale 1ns/100ps
interface nvm_rd_if;
	logic        req;
	logic [16:0] addr;
	logic        ack;
	logic [7:0]  data;

	modport master (output req, output addr, input ack, input data);
	modport slave (input req, input addr, output ack, output data);
endinterface : nvm_rd_if

/* File: tb/dbg_opt_loader_test.sv */
`timescale 1ns/100ps
module dbg_opt_loader_test;
	logic        clk           = 1'b0;
	logic        rst           = 1'b1;
	logic        bootSwap      = 1'b0;
	logic        ocdActive     = 1'b0;
	logic        nvmAck        = 1'b0;
	logic [7:0]  nvmData       = 8'h00;
	logic [1:0]  optIdx        = 2'h0;
	logic [3:0]  avs_address   = 4'h0;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        nvmReq, cpuHold, dbgEnable, eraseOnFail, cfgError, avs_waitrequest;
	logic [16:0] nvmAddr, optAddr;
	logic [31:0] avs_readdata;
	int          err_total     = 0;
	int          compares      = 0;

	always #2 clk = ~clk;

	dbg_opt_loader dut (.clk(clk), .rst(rst), .bootSwap(bootSwap), .ocdActive(ocdActive),
		.nvmReq(nvmReq), .nvmAddr(nvmAddr), .nvmAck(nvmAck), .nvmData(nvmData),
		.optIdx(optIdx), .optAddr(optAddr), .cpuHold(cpuHold), .dbgEnable(dbgEnable),
		.eraseOnFail(eraseOnFail), .cfgError(cfgError), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("Checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Waitrequest sampled at the rising edge; request stands until it is low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			err_total++;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic load(input logic [7:0] b, input logic sw);
		int n;
		n = 0;
		@(posedge clk);
		bootSwap <= sw;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		chk("cpuHold in reset", cpuHold, 32'h1);
		rst <= 1'b0;
		@(negedge clk);
		while (nvmReq !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20) begin
			err_total++;
		end
		chk("nvmAddr", nvmAddr, sw ? 32'h010C3 : 32'h000C3);
		@(posedge clk);
		nvmData <= b;
		nvmAck <= 1'b1;
		@(posedge clk);
		nvmAck <= 1'b0;
		nvmData <= ~b;
		n = 0;
		while (cpuHold !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20) begin
			err_total++;
		end
		repeat (3) @(negedge clk);
		chk("nvmReq after load", nvmReq, 32'h0);
	endtask : load

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic decode_table();
		logic [7:0] b [5] = '{8'h04, 8'h84, 8'h85, 8'h05, 8'h80};
		logic [2:0] e [5] = '{3'b000, 3'b110, 3'b100, 3'b001, 3'b001};
		for (int i = 0; i < 5; i++) begin
			load(b[i], 1'b0);
			chk("cfgError", cfgError, e[i][0]);
			// Outputs of a faulty byte are left open
			if (e[i][0] == 1'b0) begin
				chk("dbgEnable", dbgEnable, e[i][2]);
				chk("eraseOnFail", eraseOnFail, e[i][1]);
			end
		end
	endtask : decode_table

	task automatic swap_area();
		logic [31:0] rd;
		for (int s = 0; s < 2; s++) begin
			load(8'h85, s[0]);
			for (int i = 0; i < 4; i++) begin
				@(posedge clk);
				optIdx <= i[1:0];
				@(negedge clk);
				chk("optAddr", optAddr, (s ? 32'h010C0 : 32'h000C0) + i);
			end
			bus(1'b0, 4'h1, 32'h0, rd);
			chk("status", rd, {27'h0, s[0], 4'h3});
		end
	endtask : swap_area

	task automatic hold_after_load();
		logic [31:0] rd;
		load(8'h84, 1'b0);
		@(posedge clk);
		bootSwap <= 1'b1;
		nvmData <= 8'h05;
		nvmAck <= 1'b1;
		@(posedge clk);
		nvmAck <= 1'b0;
		bus(1'b1, 4'h0, 32'hFF, rd);
		repeat (8) @(negedge clk);
		chk("held controls", {cpuHold, dbgEnable, eraseOnFail, cfgError}, 32'h6);
		chk("held optAddr", optAddr, 32'h000C0 + optIdx);
		bus(1'b0, 4'h0, 32'h0, rd);
		chk("read-only byte", rd, 32'h84);
	endtask : hold_after_load

	task automatic regs();
		logic [31:0] rd;
		load(8'h85, 1'b0);
		bus(1'b0, 4'h0, 32'h0, rd);
		chk("byte idle", rd, 32'h85);
		@(posedge clk);
		ocdActive <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, 4'h0, 32'h0, rd);
		chk("byte in debug", rd, 32'h81);
		bus(1'b0, 4'h3, 32'h0, rd);
		chk("fetch address", rd, 32'h000C3);
		bus(1'b0, 4'h9, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, 4'h2, 32'h1, rd);
		bus(1'b0, 4'h2, 32'h0, rd);
		chk("ctrl readback", rd, 32'h1);
		bus(1'b0, 4'h1, 32'h0, rd);
		chk("swap waits for reset", rd, 32'h3);
		// Bits 4 and 1 set tell a mask on the wrong bits apart
		load(8'h93, 1'b0);
		chk("cfgError 93", cfgError, 32'h1);
		bus(1'b0, 4'h0, 32'h0, rd);
		chk("masked bits 3 to 1", rd, 32'h91);
		@(posedge clk);
		ocdActive <= 1'b0;
	endtask : regs

	initial begin
		decode_table();
		swap_area();
		hold_after_load();
		regs();
		test_done();
	end

	// Generous margin over the roughly 300 cycles of the sequence
	initial begin
		#20000;
		err_total++;
		test_done();
	end
endmodule : dbg_opt_loader_test
